// ### logic/fwp_core.sv
// Write protection, write-enable latch and suspend/row-lock register
//
// How it works
// - Codes 1,2,3 protect top one, two, four blocks; codes 0 and 15 none.
// - Codes 4 through 11 protect all; codes 12,13,14 protect bottom four, two, one.
// - Program or erase aimed inside the protected range is inhibited.
// - Whole-array erase is ignored unless all block-protect bits are zero.
// - Suspend during program sets program-suspended flag; resume clears it.
// - Suspend during erase sets erase-suspended flag; resume clears it.
// - Row lock bits 4..7 lock rows 0..3; locked row programming refused.
// - Row lock bits are one-time: once one they return to zero only at reset.
// - Status register unwritable while write-disable bit set and protect pin low.
// - Program, erase and register writes ignored unless write-enable latch set.
// - Latch clears on completion of any write, program, erase, or disable command.
// - All write sequences ignored while the supply-low indication is active.
// - Bits 0 and 1 of the lock register are reserved, zero; all reset zero.
`timescale 1ns/1ps
module fwp_core
  import fwp_pkg::*;
#(
  parameter int unsigned BLOCK_BITS = fwp_pkg::FWP_BLOCK_BITS
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // Device pins, asynchronous
  input  wire logic                          wp_n_pin,
  input  wire logic                          supply_low_pin,
  // Decoded instructions, one-cycle pulses
  input  wire logic                          write_enable_cmd,
  input  wire logic                          write_disable_cmd,
  input  wire logic                          status_write_cmd,
  input  wire logic [7:0]                    status_write_data,
  input  wire logic                          func_write_cmd,
  input  wire logic [7:0]                    func_write_data,
  input  wire logic                          program_cmd,
  input  wire logic                          erase_cmd,
  input  wire logic                          whole_array_erase_cmd,
  input  wire logic                          info_row_prog_cmd,
  input  wire logic [1:0]                    info_row_sel,
  input  wire logic [fwp_pkg::FWP_ADDR_W-1:0] op_addr,
  input  wire logic                          suspend_cmd,
  input  wire logic                          resume_cmd,
  // Array engine handshake
  input  wire logic                          op_done,
  output logic                               program_start_q,
  output logic                               erase_start_q,
  output logic                               info_row_start_q,
  output logic                               engine_suspend_q,
  output logic                               engine_resume_q,
  // Register views and refusal indication
  output logic [7:0]                         status_reg_q,
  output logic [7:0]                         suspend_and_row_lock_q,
  output logic                               cmd_ignored_q
);

  import fwp_pkg::*;

  localparam int unsigned NUM_BLOCKS = 1 << BLOCK_BITS;

  // Synchronised pins
  logic wp_n_s;
  logic supply_low_s;

  fwp_sync3 #(
    .RESET_VAL (1'b1)
  ) u_sync_wp (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .pin_async (wp_n_pin),
    .level_q   (wp_n_s)
  );

  // Reset to low so writes are not locked out before the pin settles
  fwp_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_vlow (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .pin_async (supply_low_pin),
    .level_q   (supply_low_s)
  );

  fwp_state_e state_q;
  fwp_state_e state_d;

  // Status and suspend/row-lock register fields
  wire       status_write_disable   = status_reg_q[FWP_SR_WR_DIS];
  wire [3:0] bp                     = status_reg_q[FWP_SR_BP_LSB +: FWP_SR_BP_W];
  wire       write_enable_latch     = status_reg_q[FWP_SR_LATCH];
  wire [3:0] irl                    = suspend_and_row_lock_q[FWP_FR_IRL_LSB +: FWP_FR_IRL_W];
  wire       program_suspended_flag = suspend_and_row_lock_q[FWP_FR_PGM_SUS];
  wire       erase_suspended_flag   = suspend_and_row_lock_q[FWP_FR_ERS_SUS];

  // Block index, address bits above the density are don't-care
  wire [7:0] addr_blk = op_addr[FWP_BLOCK_MSB:FWP_BLOCK_LSB];

  function automatic logic blk_protected(input logic [3:0] code, input logic [7:0] blk8);
    int unsigned span;
    int unsigned blk;
    logic        top;
    span = 0;
    blk  = int'(blk8) % NUM_BLOCKS;
    top  = 1'b0;
    if (code >= FWP_BP_TOP_LO && code <= FWP_BP_TOP_HI) begin
      span = 1 << (int'(code) - 1);
      top  = 1'b1;
    end else if (code > FWP_BP_TOP_HI && code <= FWP_BP_ALL_HI) begin
      span = NUM_BLOCKS;
    end else if (code >= FWP_BP_BOT_LO && code <= FWP_BP_BOT_HI) begin
      span = 1 << (FWP_BP_BOT_REF - int'(code));
    end
    if (span >= NUM_BLOCKS) begin
      blk_protected = (span != 0);
    end else if (top) begin
      blk_protected = (blk >= NUM_BLOCKS - span);
    end else begin
      blk_protected = (blk < span);
    end
  endfunction

  // Admission decode
  wire idle      = (state_q == FWP_ST_IDLE);
  wire busy      = (state_q == FWP_ST_PROG) || (state_q == FWP_ST_ERASE);
  wire addr_prot = blk_protected(bp, addr_blk);
  wire sr_locked = status_write_disable && !wp_n_s;
  wire wr_ok     = write_enable_latch && !supply_low_s && idle;
  wire row_lock  = irl[info_row_sel];

  wire acc_sr    = status_write_cmd && wr_ok && !sr_locked;
  wire acc_fr    = func_write_cmd && wr_ok;
  wire acc_prog  = program_cmd && wr_ok && !addr_prot;
  wire acc_erase = erase_cmd && wr_ok && !addr_prot;
  wire acc_chip  = whole_array_erase_cmd && wr_ok && (bp == FWP_BP_NONE);
  wire acc_irp   = info_row_prog_cmd && wr_ok && !row_lock;

  wire any_wcmd  = status_write_cmd || func_write_cmd || program_cmd || erase_cmd
                   || whole_array_erase_cmd || info_row_prog_cmd;
  wire any_acc   = acc_sr || acc_fr || acc_prog || acc_erase || acc_chip || acc_irp;
  wire op_finish = busy && op_done;
  wire susp_prog = suspend_cmd && (state_q == FWP_ST_PROG);
  wire susp_ers  = suspend_cmd && (state_q == FWP_ST_ERASE);
  wire res_prog  = resume_cmd && (state_q == FWP_ST_PGM_HOLD);
  wire res_ers   = resume_cmd && (state_q == FWP_ST_ERS_HOLD);

  // Operation sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      FWP_ST_IDLE: begin
        if (acc_prog || acc_irp) begin
          state_d = FWP_ST_PROG;
        end else if (acc_erase || acc_chip) begin
          state_d = FWP_ST_ERASE;
        end
      end
      FWP_ST_PROG: begin
        if (op_done) begin
          state_d = FWP_ST_IDLE;
        end else if (suspend_cmd) begin
          state_d = FWP_ST_PGM_HOLD;
        end
      end
      FWP_ST_ERASE: begin
        if (op_done) begin
          state_d = FWP_ST_IDLE;
        end else if (suspend_cmd) begin
          state_d = FWP_ST_ERS_HOLD;
        end
      end
      FWP_ST_PGM_HOLD: begin
        if (resume_cmd) begin
          state_d = FWP_ST_PROG;
        end
      end
      FWP_ST_ERS_HOLD: begin
        if (resume_cmd) begin
          state_d = FWP_ST_ERASE;
        end
      end
      default: begin
        state_d = FWP_ST_IDLE;
      end
    endcase
  end

  // Next register images; completion beats suspend in the same cycle
  wire sp_now  = susp_prog && !op_done;
  wire se_now  = susp_ers && !op_done;
  wire latch_clr = acc_sr || acc_fr || op_finish || write_disable_cmd;
  // A latch request in the completing cycle is kept
  wire latch_d   = write_enable_cmd ? 1'b1 : (latch_clr ? 1'b0 : write_enable_latch);
  wire wip_d   = (state_d == FWP_ST_PROG) || (state_d == FWP_ST_ERASE);

  wire [5:0] sr_hi_d = acc_sr ? status_write_data[7:2] : status_reg_q[7:2];

  wire [3:0] irl_d = acc_fr ? (irl | func_write_data[FWP_FR_IRL_LSB +: FWP_FR_IRL_W])
                            : irl;
  wire prog_susp_d  = sp_now ? 1'b1 : (res_prog ? 1'b0 : program_suspended_flag);
  wire erase_susp_d = se_now ? 1'b1 : (res_ers ? 1'b0 : erase_suspended_flag);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q                <= FWP_ST_IDLE;
      status_reg_q           <= FWP_SR_RESET;
      suspend_and_row_lock_q <= FWP_FR_RESET;
      program_start_q        <= 1'b0;
      erase_start_q          <= 1'b0;
      info_row_start_q       <= 1'b0;
      engine_suspend_q       <= 1'b0;
      engine_resume_q        <= 1'b0;
      cmd_ignored_q          <= 1'b0;
    end else begin
      state_q                <= state_d;
      status_reg_q           <= {sr_hi_d, latch_d, wip_d};
      suspend_and_row_lock_q <= {irl_d, erase_susp_d, prog_susp_d, {FWP_FR_RSVD_W{1'b0}}};
      program_start_q        <= acc_prog;
      erase_start_q          <= acc_erase || acc_chip;
      info_row_start_q       <= acc_irp;
      engine_suspend_q       <= sp_now || se_now;
      engine_resume_q        <= res_prog || res_ers;
      cmd_ignored_q          <= any_wcmd && !any_acc;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_prog_running;
    program_start_q ##0 (state_q == FWP_ST_PROG);
  endsequence

  sequence s_prog_suspending;
    suspend_cmd && !op_done && (state_q == FWP_ST_PROG);
  endsequence

  property p_top_blocks;
    (bp == FWP_BP_TOP_LO) && (addr_blk[BLOCK_BITS-1:0] == NUM_BLOCKS - 1)
      && (program_cmd || erase_cmd) |=> !program_start_q && !erase_start_q;
  endproperty
  a_top_blocks: assert property (p_top_blocks) else $error("top block programmed");

  property p_all_blocks;
    (bp > FWP_BP_TOP_HI) && (bp <= FWP_BP_ALL_HI) && (program_cmd || erase_cmd)
      |=> !program_start_q && !erase_start_q;
  endproperty
  a_all_blocks: assert property (p_all_blocks) else $error("all-protect leaked");

  property p_prot_inhibit;
    addr_prot && (program_cmd || erase_cmd) |=> !program_start_q && !erase_start_q
      && cmd_ignored_q;
  endproperty
  a_prot_inhibit: assert property (p_prot_inhibit) else $error("protected op");

  property p_chip_erase;
    whole_array_erase_cmd && (bp != FWP_BP_NONE) |=> !erase_start_q;
  endproperty
  a_chip_erase: assert property (p_chip_erase) else $error("chip erase with BP");

  // Flag must be set after the suspend and still set one cycle later unless a resume was taken
  property p_prog_susp;
    s_prog_suspending |=> program_suspended_flag && !erase_suspended_flag
      && !status_reg_q[FWP_SR_WIP] ##1 (program_suspended_flag || $past(resume_cmd));
  endproperty
  a_prog_susp: assert property (p_prog_susp) else $error("program suspend flag");

  property p_resume;
    (program_suspended_flag || erase_suspended_flag) && resume_cmd
      |=> !program_suspended_flag && !erase_suspended_flag && status_reg_q[FWP_SR_WIP];
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not clear");

  property p_erase_susp;
    suspend_cmd && !op_done && (state_q == FWP_ST_ERASE)
      |=> erase_suspended_flag && engine_suspend_q;
  endproperty
  a_erase_susp: assert property (p_erase_susp) else $error("erase suspend flag");

  property p_row_lock;
    info_row_prog_cmd && row_lock |=> !info_row_start_q;
  endproperty
  a_row_lock: assert property (p_row_lock) else $error("locked row programmed");

  property p_otp;
    |irl |=> ((irl & $past(irl)) == $past(irl));
  endproperty
  a_otp: assert property (p_otp) else $error("row lock cleared");

  property p_sr_locked;
    sr_locked && status_write_cmd |=> $stable(status_reg_q[7:2]);
  endproperty
  a_sr_locked: assert property (p_sr_locked) else $error("locked status changed");

  property p_latch_gate;
    !write_enable_latch && any_wcmd |=> cmd_ignored_q && !program_start_q && !erase_start_q;
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("write without latch");

  // Window covers the slowest engine finish seen by a plain program
  property p_latch_clear;
    s_prog_running ##[1:20] (op_done && busy && !write_enable_cmd) |=> !write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept");

  property p_supply_low;
    supply_low_s && any_wcmd |=> cmd_ignored_q;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("write at low supply");

  property p_reserved;
    suspend_and_row_lock_q[FWP_FR_RSVD_W-1:0] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  // Top four blocks, or the whole array where fewer blocks exist
  property p_saturate;
    (bp == FWP_BP_TOP_HI) && (program_cmd || erase_cmd)
      && ((NUM_BLOCKS <= 4) || (int'(addr_blk) % NUM_BLOCKS >= NUM_BLOCKS - 4))
      |=> !program_start_q && !erase_start_q;
  endproperty
  a_saturate: assert property (p_saturate) else $error("top span leaked");

endmodule

// ### logic/fwp_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fwp_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Asynchronous pin and its filtered level
  input  wire logic pin_async,
  output logic      level_q
);

  logic meta_q;
  logic s2_q;
  logic s3_q;

  // Level moves only when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q  <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      meta_q <= pin_async;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule

// ### shared/fwp_pkg.sv
// Shared constants for the flash write-protection block
package fwp_pkg;

  // Address layout: 24-bit byte address, 64 KB protection blocks
  localparam int unsigned FWP_ADDR_W     = 24;
  localparam int unsigned FWP_BLOCK_LSB  = 16;
  localparam int unsigned FWP_BLOCK_MSB  = 23;
  // Largest density holds eight 64 KB blocks
  localparam int unsigned FWP_BLOCK_BITS = 3;

  // Status register field positions
  localparam int unsigned FWP_SR_WIP     = 0;
  localparam int unsigned FWP_SR_LATCH   = 1;
  localparam int unsigned FWP_SR_BP_LSB  = 2;
  localparam int unsigned FWP_SR_BP_W    = 4;
  localparam int unsigned FWP_SR_QUAD_EN = 6;
  localparam int unsigned FWP_SR_WR_DIS  = 7;
  localparam logic [7:0]  FWP_SR_RESET   = 8'h00;

  // Suspend and row-lock register field positions
  localparam int unsigned FWP_FR_RSVD_W  = 2;
  localparam int unsigned FWP_FR_PGM_SUS = 2;
  localparam int unsigned FWP_FR_ERS_SUS = 3;
  localparam int unsigned FWP_FR_IRL_LSB = 4;
  localparam int unsigned FWP_FR_IRL_W   = 4;
  localparam logic [7:0]  FWP_FR_RESET   = 8'h00;

  // Block-protect code boundaries
  localparam logic [3:0]  FWP_BP_NONE     = 4'h0;
  localparam logic [3:0]  FWP_BP_TOP_LO   = 4'h1;
  localparam logic [3:0]  FWP_BP_TOP_HI   = 4'h3;
  localparam logic [3:0]  FWP_BP_ALL_HI   = 4'hB;
  localparam logic [3:0]  FWP_BP_BOT_LO   = 4'hC;
  localparam logic [3:0]  FWP_BP_BOT_HI   = 4'hE;
  // Bottom span is 2^(FWP_BP_BOT_REF - code)
  localparam int unsigned FWP_BP_BOT_REF  = 14;

  // Operation sequencer states
  typedef enum logic [2:0] {
    FWP_ST_IDLE  = 3'b000,
    FWP_ST_PROG  = 3'b001,
    FWP_ST_ERASE = 3'b010,
    FWP_ST_PGM_HOLD = 3'b011,
    FWP_ST_ERS_HOLD = 3'b100
  } fwp_state_e;

endpackage

// ### sim/fwp_engine_model.sv
// Array engine stand-in that finishes each operation after a fixed delay
`timescale 1ns/1ps
module fwp_engine_model #(
  parameter int DLY = 12
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Engine handshake
  input  wire logic start,
  input  wire logic suspend,
  input  wire logic resume,
  output logic      done_q
);
  int   cnt_q;
  logic run_q;
  logic hold_q;

  // Count freezes while suspended; suspend arrives a cycle after the core holds, so done can still land in it
  always_ff @(posedge clk_sys) begin
    done_q <= 1'b0;
    if (!rst_n) begin
      run_q  <= 1'b0;
      hold_q <= 1'b0;
      cnt_q  <= 0;
    end else if (start) begin
      run_q <= 1'b1;
      cnt_q <= DLY;
    end else if (suspend) begin
      hold_q <= 1'b1;
    end else if (resume) begin
      hold_q <= 1'b0;
    end else if (run_q && !hold_q) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) begin
        run_q  <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
endmodule

// ### sim/test_flash_write_protection.sv
// Self-checking bench for the write-protection core
`timescale 1ns/1ps
module test_flash_write_protection;
  import fwp_pkg::*;
  logic        clk_sys        = 1'b0;
  logic        rst_n          = 1'b0;
  logic        wp_n_pin       = 1'b1;
  logic        supply_low_pin = 1'b0;
  logic [9:0]  cmd            = '0;
  logic [7:0]  wdata          = '0;
  logic [23:0] addr           = '0;
  logic        op_done;
  logic        st_pp;
  logic        st_er;
  logic        st_ir;
  logic        eng_sus;
  logic        eng_res;
  logic        ign;
  logic [7:0]  sr;
  logic [7:0]  fr;
  int          n_errors       = 0;
  int          cmp_count      = 0;

  always #5 clk_sys = ~clk_sys;

  fwp_core #(.BLOCK_BITS(3)) u_fwp_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .wp_n_pin(wp_n_pin),
    .supply_low_pin(supply_low_pin), .write_enable_cmd(cmd[0]),
    .write_disable_cmd(cmd[1]), .status_write_cmd(cmd[2]),
    .status_write_data(wdata), .func_write_cmd(cmd[3]), .func_write_data(wdata),
    .program_cmd(cmd[4]), .erase_cmd(cmd[5]), .whole_array_erase_cmd(cmd[6]),
    .info_row_prog_cmd(cmd[7]), .info_row_sel(addr[1:0]), .op_addr(addr),
    .suspend_cmd(cmd[8]), .resume_cmd(cmd[9]), .op_done(op_done),
    .program_start_q(st_pp), .erase_start_q(st_er), .info_row_start_q(st_ir),
    .engine_suspend_q(eng_sus), .engine_resume_q(eng_res),
    .status_reg_q(sr), .suspend_and_row_lock_q(fr), .cmd_ignored_q(ign));

  fwp_engine_model #(.DLY(12)) u_fwp_engine_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(st_pp | st_er | st_ir),
    .suspend(eng_sus), .resume(eng_res), .done_q(op_done));

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One command pulse; outputs are read one step after the taking edge
  task automatic issue(input int k, input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cmd[k] <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk_sys);
    cmd <= '0;
    #1;
  endtask

  task automatic wr(input int k, input logic [23:0] a, input logic [7:0] d);
    issue(0, '0, '0);
    issue(k, a, d);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 100 && sr[0] !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(sr[0], 1'b0);
  endtask

  // Pins need several edges to pass the synchronisers
  task automatic pins(input logic w, input logic s);
    @(posedge clk_sys);
    wp_n_pin       <= w;
    supply_low_pin <= s;
    repeat (6) @(posedge clk_sys);
  endtask

  function automatic logic prot(input int c, input int b);
    if (c >= 1 && c <= 3) return b >= 8 - (1 << (c - 1));
    if (c >= 4 && c <= 11) return 1'b1;
    if (c >= 12 && c <= 14) return b < (1 << (14 - c));
    return 1'b0;
  endfunction

  task automatic t_latch();
    chk(sr, 8'h00);
    chk(fr, 8'h00);
    issue(4, '0, '0);
    chk(ign, 1'b1);
    issue(0, '0, '0);
    chk(sr[1], 1'b1);
    issue(1, '0, '0);
    chk(sr[1], 1'b0);
    issue(4, '0, '0);
    chk(st_pp, 1'b0);
    wr(4, '0, '0);
    chk(st_pp, 1'b1);
    wait_idle();
    chk(sr[1], 1'b0);
    wr(2, '0, 8'h00);
    chk(sr[1], 1'b0);
  endtask

  // Odd blocks use erase, even ones program
  task automatic t_decode();
    logic p;
    for (int c = 0; c < 16; c++) begin
      wr(2, '0, {2'b00, 4'(c), 2'b00});
      chk(sr, {2'b00, 4'(c), 2'b00});
      for (int b = 0; b < 8; b++) begin
        p = prot(c, b);
        wr(b % 2 ? 5 : 4, {8'(b), 16'h0000}, '0);
        chk(ign, p);
        chk(b % 2 ? st_er : st_pp, !p);
        if (!p) wait_idle();
      end
    end
    issue(1, '0, '0);
    wr(6, '0, '0);
    chk(ign, 1'b1);
    wr(2, '0, 8'h00);
    wr(6, '0, '0);
    chk(st_er, 1'b1);
    wait_idle();
  endtask

  task automatic t_suspend();
    for (int k = 0; k < 2; k++) begin
      wr(k ? 5 : 4, '0, '0);
      issue(8, '0, '0);
      chk(eng_sus, 1'b1);
      chk(fr[2+k], 1'b1);
      issue(9, '0, '0);
      chk(eng_res, 1'b1);
      chk(fr[2+k], 1'b0);
      wait_idle();
    end
  endtask

  task automatic t_rowlock();
    wr(3, '0, 8'h2F);
    chk(fr, 8'h20);
    wr(7, 24'h000001, '0);
    chk(ign, 1'b1);
    issue(1, '0, '0);
    wr(7, '0, '0);
    chk(st_ir, 1'b1);
    wait_idle();
    repeat (14) @(posedge clk_sys);
    wr(3, '0, 8'h00);
    chk(fr, 8'h20);
  endtask

  task automatic t_pins();
    wr(2, '0, 8'h80);
    pins(1'b0, 1'b0);
    wr(2, '0, 8'h00);
    chk(sr, 8'h82);
    pins(1'b1, 1'b0);
    wr(2, '0, 8'h00);
    chk(sr, 8'h00);
    pins(1'b0, 1'b0);
    wr(2, '0, 8'h40);
    chk(sr, 8'h40);
    pins(1'b1, 1'b1);
    wr(4, '0, '0);
    chk(st_pp, 1'b0);
    chk(ign, 1'b1);
    pins(1'b1, 1'b0);
    issue(1, '0, '0);
  endtask

  // Whole run is under two thousand cycles
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_latch();
    t_decode();
    t_suspend();
    t_rowlock();
    t_pins();
    tally_and_finish();
  end
endmodule
